/* File: logic/mas_pkg.sv */
package mas_pkg;
    localparam int ROW_W = 8;
    localparam int NUM_ROWS = 256;
    localparam int PORT_W = 6;
    localparam int NUM_PORTS = 64;
    localparam int CNT_W = 2;
    localparam int NUM_CLASS = 4;
    localparam int NUM_IRQ = 4;
    // table entry: {valid, pinned, remote, class[1:0], port[5:0], count[1:0]}
    localparam int ENT_W = 13;
    localparam int ENT_CNT_LSB = 0;
    localparam int ENT_PORT_LSB = 2;
    localparam int ENT_CLASS_LSB = 8;
    localparam int ENT_REMOTE_BIT = 10;
    localparam int ENT_PINNED_BIT = 11;
    localparam int ENT_VALID_BIT = 12;
    // register byte offsets
    localparam logic [7:0] REG_CLASS_CFG0 = 8'h00;
    localparam logic [7:0] REG_CLASS_CFG1 = 8'h04;
    localparam logic [7:0] REG_CLASS_CFG2 = 8'h08;
    localparam logic [7:0] REG_CLASS_CFG3 = 8'h0C;
    localparam logic [7:0] REG_SCAN_CTRL = 8'h10;
    localparam logic [7:0] REG_SCAN_STATUS = 8'h14;
    localparam logic [7:0] REG_EVENT_STICKY = 8'h18;
    localparam logic [7:0] REG_PORT_FILT_LO = 8'h1C;
    localparam logic [7:0] REG_PORT_FILT_HI = 8'h20;
    localparam logic [7:0] REG_IRQ_LATCH = 8'h24;
    localparam logic [7:0] REG_IRQ_MASK = 8'h28;
    localparam logic [7:0] REG_IRQ_PEND = 8'h2C;
    localparam logic [7:0] REG_LEARN_CFG = 8'h30;
    // class cfg fields: unit [2:0], period [19:4]
    localparam int UNIT_LSB = 0;
    localparam int PERIOD_LSB = 4;
    localparam int PERIOD_W = 16;
    // scan ctrl fields
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_ABORT_BIT = 2;
    localparam int CTRL_HALT_BIT = 3;
    localparam int CTRL_FAPPLY_BIT = 4;
    localparam int CTRL_FREMOTE_BIT = 5;
    localparam int CTRL_CLASS_LSB = 8;
    // learn cfg fields
    localparam int LCFG_LIMIT_LSB = 0;
    localparam int LCFG_PINREF_BIT = 2;
    // event sticky bits
    localparam int EV_BEGUN = 0;
    localparam int EV_DONE = 1;
    localparam int EV_INCR = 2;
    localparam int EV_EVICT = 3;
    // irq source bits
    localparam int IRQ_ACL = 0;
    localparam int IRQ_PORT_CAP = 1;
    localparam int IRQ_FID_CAP = 2;
    localparam int IRQ_TBL_DONE = 3;
    // tick unit: 0 off, 1 = 1 us, 2 = 10 us, 3 = 100 us, 4+ = 100 us
    localparam int UNIT_US_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int CYC_PER_US = UNIT_US_NS / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        SC_IDLE = 5'b00001,
        SC_READ = 5'b00010,
        SC_EVAL = 5'b00100,
        SC_NEXT = 5'b01000,
        SC_DONE = 5'b10000
    } mas_scan_st_t;
endpackage

/* File: logic/mas_tick_gen.sv */
`timescale 1ns/1ps
module mas_tick_gen (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [2:0] unit_sel_i,
    input wire logic [mas_pkg::PERIOD_W-1:0] period_i,
    output logic due_o
);
    import mas_pkg::*;
    typedef struct packed {
        logic [9:0] pre;
        logic [6:0] dec;
        logic [PERIOD_W-1:0] units;
        logic due;
    } mas_tick_t;
    mas_tick_t st_ff, nxt_st;

    function automatic logic [6:0] dec_top(input logic [2:0] u);
        case (u)
            3'd1: dec_top = 7'd0;
            3'd2: dec_top = 7'd9;
            3'd3: dec_top = 7'd99;
            default: dec_top = 7'd99;
        endcase
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.due = 1'b0;
        if (unit_sel_i == 3'd0) begin
            nxt_st.pre = '0;
            nxt_st.dec = '0;
            nxt_st.units = '0;
        end else if (st_ff.pre != 10'(CYC_PER_US - 1)) begin
            nxt_st.pre = st_ff.pre + 10'd1;
        end else begin
            nxt_st.pre = '0;
            // units 4 and up reuse the 100 us decade count of unit 3
            if (st_ff.dec < dec_top(unit_sel_i)) begin
                nxt_st.dec = st_ff.dec + 7'd1;
            end else begin
                nxt_st.dec = '0;
                if (st_ff.units + 16'd1 >= period_i) begin
                    nxt_st.units = '0;
                    nxt_st.due = 1'b1;
                end else begin
                    nxt_st.units = st_ff.units + 16'd1;
                end
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign due_o = st_ff.due;
endmodule

/* File: logic/mas_irq_agg.sv */
`timescale 1ns/1ps
module mas_irq_agg (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [mas_pkg::NUM_IRQ-1:0] src_i,
    input wire logic [mas_pkg::NUM_IRQ-1:0] clr_i,
    input wire logic [mas_pkg::NUM_IRQ-1:0] mask_i,
    output logic [mas_pkg::NUM_IRQ-1:0] latch_o,
    output logic [mas_pkg::NUM_IRQ-1:0] pend_o,
    output logic irq_o
);
    import mas_pkg::*;
    typedef struct packed {
        logic [NUM_IRQ-1:0] lat;
    } mas_irq_t;
    mas_irq_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // set beats a simultaneous clear
        nxt_st.lat = (st_ff.lat & ~clr_i) | src_i;
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign latch_o = st_ff.lat;
    assign pend_o = st_ff.lat & mask_i;
    assign irq_o = |pend_o;
endmodule

/* File: logic/mas_age_scanner.sv */
`timescale 1ns/1ps
// Summary of operation
// - only unpinned entries are aging candidates; pinned ones untouched
// - candidate already at limit count is evicted from the table
// - candidate below limit is written back with count plus one
// - frame from matching source clears that entry's count
// - passes launch automatically once configured, no cpu help
// - pass interval from unit and period; four classes
// - unit value zero disables periodic aging; nonzero enables it
// - hold bit suspends automatic aging; clearing resumes
// - start shot launches pass now if idle, ignored mid-pass; abort shot kills pass now
// - halt bit lets current pass finish then stays idle
// - filters restrict aging to chosen local ports or remote entries
// - filters act only while filter-apply is set
// - cpu scans use the same filter settings
// - next row pointer and pass-in-progress readable
// - sticky begun flag on auto pass start, done flag on finish
// - sticky flags for any increment and any eviction
// - sticky latch per interrupt source, individually maskable
// - pending view shows sources asserting the interrupt
// - latch acl hit interrupt on matched rule with irq action
// - latch port learn cap interrupt when port enable set
// - latch domain learn cap interrupt when domain enable set
// - latch table op done interrupt when configured
// - frame refresh clears pinned entries only if refresh enable set
module mas_age_scanner (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [mas_pkg::ROW_W-1:0] TBL_ADDR_O,
    output logic TBL_RD_O,
    output logic TBL_WR_O,
    output logic [mas_pkg::ENT_W-1:0] TBL_WDATA_O,
    input wire logic [mas_pkg::ENT_W-1:0] TBL_RDATA_I,
    input wire logic TBL_GRANT_I,
    input wire logic CPU_SCAN_I,
    output logic CPU_SCAN_MATCH_O,
    input wire logic HIT_VALID_I,
    input wire logic [mas_pkg::ROW_W-1:0] HIT_ROW_I,
    input wire logic HIT_PINNED_I,
    output logic HIT_CLEAR_O,
    input wire logic ACL_HIT_IRQ_I,
    input wire logic PORT_LIMIT_EXCEED_I,
    input wire logic PORT_CAP_IRQ_EN_I,
    input wire logic FID_LIMIT_EXCEED_I,
    input wire logic FID_CAP_IRQ_EN_I,
    input wire logic TBL_OP_DONE_I,
    input wire logic TBL_OP_IRQ_EN_I,
    output logic IRQ_O
);
    import mas_pkg::*;

    typedef struct packed {
        logic [NUM_CLASS-1:0][2:0] unit;
        logic [NUM_CLASS-1:0][PERIOD_W-1:0] period;
        logic hold;
        logic halt;
        logic fapply;
        logic fremote;
        logic [1:0] start_class;
        logic [NUM_PORTS-1:0] port_filt;
        logic [CNT_W-1:0] limit;
        logic pin_refresh;
        logic [3:0] events;
        logic [NUM_IRQ-1:0] irq_mask;
        logic [NUM_CLASS-1:0] due_pend;
        mas_scan_st_t sc;
        logic [ROW_W-1:0] row;
        logic [1:0] cls;
        logic auto_pass;
        logic [ENT_W-1:0] ent;
        logic wr;
        logic rd;
        logic [ENT_W-1:0] wdata;
        logic hit_clr;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata_bus;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mas_top_t;
    mas_top_t st_ff, nxt_st;

    logic [NUM_CLASS-1:0] due;
    logic [NUM_IRQ-1:0] irq_latch;
    logic [NUM_IRQ-1:0] irq_pend;
    logic [NUM_IRQ-1:0] irq_src;
    logic [NUM_IRQ-1:0] irq_clr;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] rd_word;

    // shared filter decode for aging and cpu scans
    function automatic logic filt_pass(input logic [ENT_W-1:0] e, input logic apply,
                                       input logic remote, input logic [NUM_PORTS-1:0] pf);
        if (!apply) begin
            filt_pass = 1'b1;
        end else if (e[ENT_REMOTE_BIT]) begin
            filt_pass = remote;
        end else begin
            filt_pass = pf[e[ENT_PORT_LSB +: PORT_W]];
        end
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            strb_mask[i*8 +: 8] = {8{s[i]}};
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_CLASS; g++) begin : gen_tick
            mas_tick_gen u_tick (
                .CLOCK_I(CLOCK_I),
                .RST_B_I(RST_B_I),
                .unit_sel_i(st_ff.unit[g]),
                .period_i(st_ff.period[g]),
                .due_o(due[g])
            );
        end
    endgenerate

    assign irq_src[IRQ_ACL] = ACL_HIT_IRQ_I;
    assign irq_src[IRQ_PORT_CAP] = PORT_LIMIT_EXCEED_I & PORT_CAP_IRQ_EN_I;
    assign irq_src[IRQ_FID_CAP] = FID_LIMIT_EXCEED_I & FID_CAP_IRQ_EN_I;
    assign irq_src[IRQ_TBL_DONE] = TBL_OP_DONE_I & TBL_OP_IRQ_EN_I;

    assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    assign wmask = strb_mask(st_ff.wstrb);
    assign irq_clr = (wr_fire && st_ff.awaddr == REG_IRQ_LATCH) ?
                     st_ff.wdata_bus[NUM_IRQ-1:0] & wmask[NUM_IRQ-1:0] : '0;

    mas_irq_agg u_irq (
        .CLOCK_I(CLOCK_I),
        .RST_B_I(RST_B_I),
        .src_i(irq_src),
        .clr_i(irq_clr),
        .mask_i(st_ff.irq_mask),
        .latch_o(irq_latch),
        .pend_o(irq_pend),
        .irq_o(IRQ_O)
    );

    always_comb begin
        rd_word = 32'h0000_0000;
        case (S_AXI_ARADDR_I)
            REG_CLASS_CFG0, REG_CLASS_CFG1, REG_CLASS_CFG2, REG_CLASS_CFG3: begin
                rd_word[UNIT_LSB +: 3] = st_ff.unit[S_AXI_ARADDR_I[3:2]];
                rd_word[PERIOD_LSB +: PERIOD_W] = st_ff.period[S_AXI_ARADDR_I[3:2]];
            end
            REG_SCAN_CTRL: begin
                rd_word[CTRL_HOLD_BIT] = st_ff.hold;
                rd_word[CTRL_HALT_BIT] = st_ff.halt;
                rd_word[CTRL_FAPPLY_BIT] = st_ff.fapply;
                rd_word[CTRL_FREMOTE_BIT] = st_ff.fremote;
                rd_word[CTRL_CLASS_LSB +: 2] = st_ff.start_class;
            end
            REG_SCAN_STATUS: begin
                rd_word[ROW_W-1:0] = st_ff.row;
                rd_word[31] = (st_ff.sc != SC_IDLE);
            end
            REG_EVENT_STICKY: rd_word[3:0] = st_ff.events;
            REG_PORT_FILT_LO: rd_word = st_ff.port_filt[31:0];
            REG_PORT_FILT_HI: rd_word = st_ff.port_filt[63:32];
            REG_IRQ_LATCH: rd_word[NUM_IRQ-1:0] = irq_latch;
            REG_IRQ_MASK: rd_word[NUM_IRQ-1:0] = st_ff.irq_mask;
            REG_IRQ_PEND: rd_word[NUM_IRQ-1:0] = irq_pend;
            REG_LEARN_CFG: begin
                rd_word[LCFG_LIMIT_LSB +: CNT_W] = st_ff.limit;
                rd_word[LCFG_PINREF_BIT] = st_ff.pin_refresh;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        logic start_now;
        logic abort_now;
        logic [CNT_W-1:0] cnt;
        logic [3:0] ev_set;
        logic [3:0] ev_clr;
        logic [31:0] wd;
        start_now = 1'b0;
        abort_now = 1'b0;
        cnt = TBL_RDATA_I[ENT_CNT_LSB +: CNT_W];
        ev_set = '0;
        ev_clr = '0;
        wd = (st_ff.wdata_bus & wmask);
        nxt_st = st_ff;
        nxt_st.rd = 1'b0;
        nxt_st.wr = 1'b0;
        nxt_st.hit_clr = 1'b0;
        // write channel: address and data accepted in either order
        if (S_AXI_AWVALID_I && !st_ff.aw_got) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && !st_ff.w_got) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata_bus = S_AXI_WDATA_I;
            nxt_st.wstrb = S_AXI_WSTRB_I;
        end
        if (wr_fire) begin
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            case (st_ff.awaddr)
                REG_CLASS_CFG0, REG_CLASS_CFG1, REG_CLASS_CFG2, REG_CLASS_CFG3: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.unit[st_ff.awaddr[3:2]] = st_ff.wdata_bus[UNIT_LSB +: 3];
                    end
                    if (&st_ff.wstrb[2:0]) begin
                        nxt_st.period[st_ff.awaddr[3:2]] =
                            st_ff.wdata_bus[PERIOD_LSB +: PERIOD_W];
                    end
                end
                REG_SCAN_CTRL: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.hold = st_ff.wdata_bus[CTRL_HOLD_BIT];
                        nxt_st.halt = st_ff.wdata_bus[CTRL_HALT_BIT];
                        nxt_st.fapply = st_ff.wdata_bus[CTRL_FAPPLY_BIT];
                        nxt_st.fremote = st_ff.wdata_bus[CTRL_FREMOTE_BIT];
                        start_now = st_ff.wdata_bus[CTRL_START_BIT];
                        abort_now = st_ff.wdata_bus[CTRL_ABORT_BIT];
                    end
                    if (st_ff.wstrb[1]) begin
                        nxt_st.start_class = st_ff.wdata_bus[CTRL_CLASS_LSB +: 2];
                    end
                end
                REG_EVENT_STICKY: ev_clr = wd[3:0];
                REG_PORT_FILT_LO: nxt_st.port_filt[31:0] =
                    (st_ff.port_filt[31:0] & ~wmask) | wd;
                REG_PORT_FILT_HI: nxt_st.port_filt[63:32] =
                    (st_ff.port_filt[63:32] & ~wmask) | wd;
                REG_IRQ_LATCH: nxt_st.bresp = RESP_OKAY;
                REG_IRQ_MASK: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.irq_mask = st_ff.wdata_bus[NUM_IRQ-1:0];
                    end
                end
                REG_LEARN_CFG: begin
                    if (st_ff.wstrb[0]) begin
                        nxt_st.limit = st_ff.wdata_bus[LCFG_LIMIT_LSB +: CNT_W];
                        nxt_st.pin_refresh = st_ff.wdata_bus[LCFG_PINREF_BIT];
                    end
                end
                REG_SCAN_STATUS, REG_IRQ_PEND: nxt_st.bresp = RESP_OKAY;
                default: nxt_st.bresp = RESP_SLVERR;
            endcase
        end
        if (st_ff.bvalid && S_AXI_BREADY_I) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
        end
        // read channel
        if (S_AXI_ARVALID_I && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_word;
            nxt_st.rresp = (S_AXI_ARADDR_I > REG_LEARN_CFG || S_AXI_ARADDR_I[1:0] != 2'b00) ?
                           RESP_SLVERR : RESP_OKAY;
        end else if (st_ff.rvalid && S_AXI_RREADY_I) begin
            nxt_st.rvalid = 1'b0;
        end
        // latch tick requests per class until a pass serves them
        for (int c = 0; c < NUM_CLASS; c++) begin
            if (due[c] && !st_ff.hold && !st_ff.halt) begin
                nxt_st.due_pend[c] = 1'b1;
            end
        end
        // frame refresh has priority on the table port over the scanner
        if (HIT_VALID_I && (!HIT_PINNED_I || st_ff.pin_refresh)) begin
            nxt_st.hit_clr = 1'b1;
        end
        case (st_ff.sc)
            SC_IDLE: begin
                if (start_now) begin
                    nxt_st.sc = SC_READ;
                    nxt_st.cls = st_ff.start_class;
                    nxt_st.auto_pass = 1'b0;
                    nxt_st.row = '0;
                end else if (!st_ff.hold && !st_ff.halt && |st_ff.due_pend) begin
                    nxt_st.sc = SC_READ;
                    nxt_st.auto_pass = 1'b1;
                    nxt_st.row = '0;
                    ev_set[EV_BEGUN] = 1'b1;
                    for (int c = NUM_CLASS - 1; c >= 0; c--) begin
                        if (st_ff.due_pend[c]) begin
                            nxt_st.cls = 2'(c);
                        end
                    end
                end
            end
            SC_READ: begin
                if (TBL_GRANT_I && !HIT_VALID_I) begin
                    nxt_st.rd = 1'b1;
                    nxt_st.sc = SC_EVAL;
                end
            end
            SC_EVAL: begin
                // table data stands only the cycle after the read pulse
                if (!st_ff.rd) begin
                    nxt_st.ent = TBL_RDATA_I;
                    nxt_st.sc = SC_NEXT;
                    if (TBL_RDATA_I[ENT_VALID_BIT] && !TBL_RDATA_I[ENT_PINNED_BIT] &&
                        TBL_RDATA_I[ENT_CLASS_LSB +: 2] == st_ff.cls &&
                        filt_pass(TBL_RDATA_I, st_ff.fapply, st_ff.fremote,
                                  st_ff.port_filt)) begin
                        nxt_st.wr = 1'b1;
                        if (cnt >= st_ff.limit) begin
                            nxt_st.wdata = '0;
                            ev_set[EV_EVICT] = 1'b1;
                        end else begin
                            nxt_st.wdata = TBL_RDATA_I;
                            nxt_st.wdata[ENT_CNT_LSB +: CNT_W] = cnt + 2'd1;
                            ev_set[EV_INCR] = 1'b1;
                        end
                    end
                end
            end
            SC_NEXT: begin
                if (st_ff.row == ROW_W'(NUM_ROWS - 1)) begin
                    nxt_st.sc = SC_DONE;
                end else begin
                    nxt_st.row = st_ff.row + 8'd1;
                    nxt_st.sc = SC_READ;
                end
            end
            SC_DONE: begin
                nxt_st.sc = SC_IDLE;
                nxt_st.row = '0;
                ev_set[EV_DONE] = 1'b1;
                if (st_ff.auto_pass) begin
                    nxt_st.due_pend[st_ff.cls] = 1'b0;
                end
            end
            default: nxt_st.sc = SC_IDLE;
        endcase
        if (abort_now && st_ff.sc != SC_IDLE) begin
            nxt_st.sc = SC_IDLE;
            nxt_st.wr = 1'b0;
            nxt_st.row = '0;
        end
        nxt_st.events = (st_ff.events & ~ev_clr) | ev_set;
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_ff <= '0;
            st_ff.sc <= SC_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign S_AXI_AWREADY_O = !st_ff.aw_got;
    assign S_AXI_WREADY_O = !st_ff.w_got;
    assign S_AXI_BVALID_O = st_ff.bvalid;
    assign S_AXI_BRESP_O = st_ff.bresp;
    assign S_AXI_ARREADY_O = !st_ff.rvalid;
    assign S_AXI_RVALID_O = st_ff.rvalid;
    assign S_AXI_RDATA_O = st_ff.rdata;
    assign S_AXI_RRESP_O = st_ff.rresp;
    assign TBL_ADDR_O = st_ff.hit_clr ? HIT_ROW_I : st_ff.row;
    assign TBL_RD_O = st_ff.rd;
    assign TBL_WR_O = st_ff.wr;
    assign TBL_WDATA_O = st_ff.wdata;
    assign HIT_CLEAR_O = st_ff.hit_clr;
    assign CPU_SCAN_MATCH_O = CPU_SCAN_I &&
        filt_pass(TBL_RDATA_I, st_ff.fapply, st_ff.fremote, st_ff.port_filt);
endmodule

/* File: verif/mas_age_scanner_asserts.sv */
`timescale 1ns/1ps
module mas_age_scanner_asserts import mas_pkg::*; (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic [ROW_W-1:0] TBL_ADDR_O,
    input wire logic TBL_RD_O,
    input wire logic TBL_WR_O,
    input wire logic [ENT_W-1:0] TBL_WDATA_O,
    input wire logic [ENT_W-1:0] TBL_RDATA_I,
    input wire logic TBL_GRANT_I,
    input wire logic HIT_VALID_I,
    input wire logic [ROW_W-1:0] HIT_ROW_I,
    input wire logic HIT_PINNED_I,
    input wire logic HIT_CLEAR_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    sequence pinned_read;
        TBL_RD_O ##1 TBL_RDATA_I[ENT_PINNED_BIT];
    endsequence
    a_pinned_kept: assert property (pinned_read |-> !TBL_WR_O [*3])
        else $error("pinned entry written");
    a_wr_count: assert property (TBL_WR_O |-> TBL_WDATA_O == '0 ||
        TBL_WDATA_O[ENT_CNT_LSB +: CNT_W] != '0) else $error("bad write-back count");
    a_hit_clear: assert property (HIT_VALID_I && !HIT_PINNED_I |=> HIT_CLEAR_O)
        else $error("hit not cleared");
    a_hit_row: assert property (HIT_CLEAR_O |-> $past(HIT_VALID_I) &&
        TBL_ADDR_O == HIT_ROW_I) else $error("hit clear row wrong");
    a_rd_pulse: assert property (TBL_RD_O |=> !TBL_RD_O) else $error("read too long");
    a_rd_grant: assert property (TBL_RD_O |-> $past(TBL_GRANT_I))
        else $error("read without grant");
    a_wr_pulse: assert property (TBL_WR_O |=> !TBL_WR_O) else $error("write too long");
    a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read not answered");
endmodule
bind mas_age_scanner mas_age_scanner_asserts u_chk (.*);

/* File: verif/mas_tbl_model.sv */
`timescale 1ns/1ps
module mas_tbl_model import mas_pkg::*; (
    input wire logic CLOCK_I,
    input wire logic [ROW_W-1:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [ENT_W-1:0] wdata_i,
    input wire logic clr_i,
    output logic [ENT_W-1:0] rdata_o
);
    logic [ENT_W-1:0] mem [NUM_ROWS];
    initial rdata_o = '0;
    // data is good only the cycle after a read, so stale use shows up
    always @(posedge CLOCK_I) begin
        rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
        if (wr_i) mem[addr_i] <= wdata_i;
        if (clr_i) mem[addr_i][ENT_CNT_LSB +: CNT_W] <= '0;
    end
endmodule

/* File: verif/mas_age_scanner_tb_top.sv */
`timescale 1ns/1ps
module mas_age_scanner_tb_top;
    import mas_pkg::*;
    logic CLOCK_I = 0, RST_B_I = 0, ah, wh, bh;
    logic [7:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
    logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0, S_AXI_ARVALID_I = 0;
    logic S_AXI_RREADY_I = 0, S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
    logic S_AXI_RVALID_O, TBL_RD_O, TBL_WR_O, HIT_CLEAR_O, CPU_SCAN_MATCH_O, IRQ_O;
    logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O, rd;
    logic [3:0] S_AXI_WSTRB_I = 4'hF;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, rsp;
    logic [ROW_W-1:0] TBL_ADDR_O, HIT_ROW_I = '0;
    logic [ENT_W-1:0] TBL_WDATA_O, TBL_RDATA_I;
    logic TBL_GRANT_I = 0, CPU_SCAN_I = 0, HIT_VALID_I = 0, HIT_PINNED_I = 0, ACL_HIT_IRQ_I = 0;
    logic PORT_LIMIT_EXCEED_I = 0, PORT_CAP_IRQ_EN_I = 0, FID_LIMIT_EXCEED_I = 0;
    logic FID_CAP_IRQ_EN_I = 0, TBL_OP_DONE_I = 0, TBL_OP_IRQ_EN_I = 0;
    int num_errors = 0, check_count = 0, cyc = 0;
    mas_age_scanner DUT (.*);
    mas_tbl_model u_tbl (.CLOCK_I(CLOCK_I), .addr_i(TBL_ADDR_O), .rd_i(TBL_RD_O),
        .wr_i(TBL_WR_O), .wdata_i(TBL_WDATA_O), .clr_i(HIT_CLEAR_O), .rdata_o(TBL_RDATA_I));
    always #5 CLOCK_I = ~CLOCK_I;
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge CLOCK_I) begin
        cyc <= cyc + 1;
        TBL_GRANT_I <= (cyc % 3) != 0; // storage busy one cycle in three
        if (cyc == 30000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= d;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        do begin
            @(negedge CLOCK_I);
            ah = S_AXI_AWREADY_O;
            wh = S_AXI_WREADY_O;
            bh = S_AXI_BVALID_O;
            @(posedge CLOCK_I);
            if (ah) S_AXI_AWVALID_I <= 1'b0;
            if (wh) S_AXI_WVALID_I <= 1'b0;
        end while (!bh);
        S_AXI_BREADY_I <= 1'b0;
        @(posedge CLOCK_I);
    endtask
    task automatic rdr(input logic [7:0] a);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I <= 1'b1;
        do begin
            @(negedge CLOCK_I);
            ah = S_AXI_ARREADY_O;
            bh = S_AXI_RVALID_O;
            rd = S_AXI_RDATA_O;
            rsp = S_AXI_RRESP_O;
            @(posedge CLOCK_I);
            if (ah) S_AXI_ARVALID_I <= 1'b0;
        end while (!bh);
        S_AXI_RREADY_I <= 1'b0;
        @(posedge CLOCK_I);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rdr(a);
        chk(rd & m, e);
    endtask
    initial begin
        for (int i = 0; i < NUM_ROWS; i++) u_tbl.mem[i] = 13'h1800;
        u_tbl.mem[0] = 13'h1000;
        u_tbl.mem[1] = 13'h1801;
        u_tbl.mem[2] = 13'h1001;
        repeat (20) @(posedge CLOCK_I);
        RST_B_I <= 1'b1;
        @(posedge CLOCK_I);
        rc(REG_SCAN_STATUS, 32'hFFFFFFFF, 32'h0);
        wr(REG_LEARN_CFG, 32'h1);
        wr(REG_SCAN_CTRL, 32'h2);
        rc(REG_SCAN_STATUS, 32'h80000000, 32'h80000000);
        do rdr(REG_SCAN_STATUS); while (rd[31] !== 1'b0);
        rc(REG_EVENT_STICKY, 32'hF, 32'hE);
        chk(u_tbl.mem[0], 32'h1001);
        chk(u_tbl.mem[1], 32'h1801);
        chk(u_tbl.mem[2], 32'h0);
        wr(REG_EVENT_STICKY, 32'hF);
        rc(REG_EVENT_STICKY, 32'hF, 32'h0);
        HIT_VALID_I <= 1'b1;
        @(posedge CLOCK_I);
        HIT_VALID_I <= 1'b0;
        repeat (2) @(posedge CLOCK_I);
        chk(u_tbl.mem[0], 32'h1000);
        {ACL_HIT_IRQ_I, PORT_LIMIT_EXCEED_I, PORT_CAP_IRQ_EN_I, FID_LIMIT_EXCEED_I} <= 4'hF;
        {FID_CAP_IRQ_EN_I, TBL_OP_DONE_I, TBL_OP_IRQ_EN_I} <= 3'h7;
        @(posedge CLOCK_I);
        {ACL_HIT_IRQ_I, PORT_LIMIT_EXCEED_I, FID_LIMIT_EXCEED_I, TBL_OP_DONE_I} <= 4'h0;
        rc(REG_IRQ_LATCH, 32'hF, 32'hF);
        rc(REG_IRQ_PEND, 32'hF, 32'h0);
        wr(REG_IRQ_MASK, 32'h5);
        rc(REG_IRQ_PEND, 32'hF, 32'h5);
        chk(IRQ_O, 32'h1);
        wr(REG_IRQ_LATCH, 32'h5);
        rc(REG_IRQ_LATCH, 32'hF, 32'hA);
        chk(IRQ_O, 32'h0);
        wr(REG_EVENT_STICKY, 32'hF);
        wr(REG_CLASS_CFG0, 32'h11);
        repeat (300) @(posedge CLOCK_I);
        rc(REG_EVENT_STICKY, 32'h1, 32'h1);
        wr(REG_SCAN_CTRL, 32'h8);
        do rdr(REG_SCAN_STATUS); while (rd[31] !== 1'b0);
        wr(REG_EVENT_STICKY, 32'hF);
        repeat (300) @(posedge CLOCK_I);
        rc(REG_EVENT_STICKY, 32'h1, 32'h0);
        wr(REG_SCAN_CTRL, 32'hA);
        rc(REG_SCAN_STATUS, 32'h80000000, 32'h80000000);
        wr(REG_SCAN_CTRL, 32'hC);
        rc(REG_SCAN_STATUS, 32'h80000000, 32'h0);
        CPU_SCAN_I <= 1'b1;
        @(posedge CLOCK_I);
        chk(CPU_SCAN_MATCH_O, 32'h1);
        conclude();
    end
endmodule
